// ---- logic/fcs_pkg.sv ----
/*
 * Constants and types shared by the flash command sequencer.
 * Assumes a 200 MHz system clock and a byte-wide flash macro beside it.
 */
package fcs_pkg;

    // Clock rate and operation times
    localparam int CLK_MHZ = 200;
    localparam int SECT_ERASE_MAX_MS = 30;
    localparam int CHIP_ERASE_MS = 30;
    localparam int PROG_MAX_US = 40;
    localparam int SEC_MAX_US = 40;
    localparam int SECT_ERASE_CYC = SECT_ERASE_MAX_MS * 1000 * CLK_MHZ;
    localparam int CHIP_ERASE_CYC = CHIP_ERASE_MS * 1000 * CLK_MHZ;
    localparam int PROG_CYC = PROG_MAX_US * CLK_MHZ;
    localparam int SEC_CYC = SEC_MAX_US * CLK_MHZ;

    // Flash addresses of the command pattern and the ID cells
    localparam logic [19:0] UNLOCK1_ADR = 20'h04555;
    localparam logic [19:0] UNLOCK2_ADR = 20'h04aaa;
    localparam logic [19:0] SEC_ADR = 20'h04f7f;
    localparam logic [19:0] ID_VENDOR_ADR = 20'h04000;
    localparam logic [19:0] ID_MACRO_ADR = 20'h04001;
    localparam logic [19:0] ID_SIZE_ADR = 20'h04002;
    localparam int SECT_LSB = 12;

    // Command data bytes
    localparam logic [7:0] UNLOCK1_DAT = 8'haa;
    localparam logic [7:0] UNLOCK2_DAT = 8'h55;
    localparam logic [7:0] CMD_PROG = 8'ha0;
    localparam logic [7:0] CMD_ERASE = 8'h80;
    localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
    localparam logic [7:0] CMD_ID_EXIT = 8'hf0;
    localparam logic [7:0] CMD_SEC = 8'ha5;
    localparam logic [7:0] SUB_SECTOR = 8'h30;
    localparam logic [7:0] SUB_CHIP = 8'h10;
    localparam logic [7:0] SEC_DAT = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] SEC_ON_BYTE = 8'h00;
    localparam int TOGGLE_BIT = 6;

    // Size codes returned in ID mode
    localparam logic [7:0] SIZE_120K = 8'h1d;
    localparam logic [7:0] SIZE_60K = 8'h0e;
    localparam logic [7:0] SIZE_48K = 8'h0b;
    localparam logic [7:0] SIZE_32K = 8'h07;
    localparam logic [7:0] SIZE_24K = 8'h05;
    localparam logic [7:0] SIZE_16K = 8'h03;
    localparam logic [7:0] SIZE_8K = 8'h01;
    localparam logic [7:0] SIZE_4K = 8'h00;

    // Bus map
    localparam int WB_AW = 24;
    localparam int REG_SPACE_BIT = 23;
    localparam logic [7:0] REG_CTRL_OFS = 8'h00;
    localparam logic [7:0] REG_STAT_OFS = 8'h04;

    // Control register: command_enable_field
    localparam int CEN_LSB = 4;
    localparam logic [3:0] CEN_RUN = 4'h3;
    localparam logic [3:0] CEN_LOCK = 4'hc;

    // Status register bits
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_ID_BIT = 1;
    localparam int ST_SEC_BIT = 2;
    localparam int ST_LDBLK_BIT = 3;
    localparam int ST_MODE_LSB = 4;

    typedef enum logic [1:0] {
        MODE_MCU,
        MODE_SERIAL,
        MODE_PARALLEL
    } fcs_mode_t;

endpackage : fcs_pkg

// ---- logic/fcs_sequencer.sv ----
/*
 * Flash command sequencer: Wishbone slave that decodes unlock command
 * sequences written into the flash window, starts operations on the
 * flash macro, reports progress by a toggling data bit, serves ID reads
 * and enforces the security protection.
 * Assumes a flash macro whose read data follows mac_adr_o combinationally
 * and which finishes each started operation within the counted time.
 */
// Chosen here: the address map and the Wishbone slave port.
// Behaviour
// - Sector erase clears one 4 kbyte sector chosen by sixth write address.
// - Sector erase accepted in MCU and serial modes, never in parallel.
// - Sector erase finishes within 30 ms of the last write.
// - No new command sequence runs while an operation is busy.
// - Busy reads flip bit 6 on every read; flipping stops when done.
// - First toggle read after starting an operation returns one.
// - Chip erase takes about 30 ms and leaves all bytes FFH.
// - ID mode returns maker byte at 04000H, macro byte at 04001H.
// - ID mode returns the size code at 04002H.
// - ID mode 04F7FH reads FFH unsecured, other value secured.
// - ID exit command returns reads to array contents.
// - Secured parallel mode blocks array reads and writes.
// - Secured serial mode refuses flash writes and RAM loader.
// - Only chip erase clears security protection.
// - Security set finishes within 40 us, toggling meanwhile.
// - Array reads unavailable while an operation runs.
// - Program and read per byte; erase per sector or whole array.
// - Watchdog held off while the serial RAM loader runs.
// - Commands run only with enable field 0011B; reset gives 1100B.
// - Unlock AAH at 04555H, 55H at 04AAAH, then the command byte.
`timescale 1ns/100ps
module fcs_sequencer #(
    parameter int SECT_ERASE_CYC = fcs_pkg::SECT_ERASE_CYC,
    parameter int CHIP_ERASE_CYC = fcs_pkg::CHIP_ERASE_CYC,
    parameter int PROG_CYC = fcs_pkg::PROG_CYC,
    parameter int SEC_CYC = fcs_pkg::SEC_CYC,
    // Arbitrary identification values
    parameter logic [7:0] VENDOR_ID = 8'h5a,
    parameter logic [7:0] MACRO_ID = 8'h3c,
    parameter logic [7:0] SIZE_CODE = fcs_pkg::SIZE_120K
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [fcs_pkg::WB_AW-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Device mode
    input wire fcs_pkg::fcs_mode_t mode_i,
    input wire logic loader_active_i,
    // Flash macro
    output logic [19:0] mac_adr_o,
    output logic [7:0] mac_wdat_o,
    output logic mac_prog_o,
    output logic mac_sect_erase_o,
    output logic mac_chip_erase_o,
    output logic mac_sec_set_o,
    input wire logic [7:0] mac_rdat_i,
    input wire logic mac_secure_i,
    // Status
    output logic busy_o,
    output logic loader_blocked_o,
    output logic wdt_disable_o
);

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_UNL1,
        ST_UNL2,
        ST_PROG,
        ST_ERA1,
        ST_ERA2,
        ST_ERA3,
        ST_SEC,
        ST_BUSY
    } fcs_state_t;

    fcs_state_t state;
    logic [31:0] busy_cnt;
    logic id_mode;
    logic tog;
    logic pend;
    logic [3:0] cen;

    logic req;
    logic is_reg;
    logic [19:0] fadr;
    logic [7:0] wdat;
    logic [7:0] rofs;
    logic run_en;
    logic busy;
    logic par_lock;
    logic prog_block;
    logic hit1;
    logic hit2;
    logic cmd_wr;
    logic rd_flash;
    logic rd_mac;
    logic [31:0] rd_word;

    // Request decode
    // A pending macro read must not be taken a second time
    assign req = cyc_i & stb_i & ~ack_o & ~pend;
    assign is_reg = adr_i[fcs_pkg::REG_SPACE_BIT];
    assign fadr = adr_i[21:2];
    assign wdat = dat_i[7:0];
    assign rofs = adr_i[7:0];
    assign busy = (state == ST_BUSY);
    assign run_en = (cen == fcs_pkg::CEN_RUN);
    assign par_lock = mac_secure_i & (mode_i == fcs_pkg::MODE_PARALLEL);
    // Secured parallel writes are refused by the same term
    // Secured serial write refusal
    assign prog_block = mac_secure_i & (mode_i != fcs_pkg::MODE_MCU);
    assign hit1 = (fadr == fcs_pkg::UNLOCK1_ADR)
        & (wdat == fcs_pkg::UNLOCK1_DAT);
    assign hit2 = (fadr == fcs_pkg::UNLOCK2_ADR)
        & (wdat == fcs_pkg::UNLOCK2_DAT);
    assign cmd_wr = req & we_i & ~is_reg & sel_i[0];
    assign rd_flash = req & ~we_i & ~is_reg;
    // Only plain array reads wait a cycle for the macro data
    assign rd_mac = rd_flash & ~busy & ~par_lock & ~id_mode;

    // Immediate read answers
    always_comb begin
        rd_word = 32'h0;
        if (is_reg) begin
            if (rofs == fcs_pkg::REG_CTRL_OFS) begin
                rd_word[fcs_pkg::CEN_LSB +: 4] = cen;
            end else if (rofs == fcs_pkg::REG_STAT_OFS) begin
                rd_word[fcs_pkg::ST_BUSY_BIT] = busy;
                rd_word[fcs_pkg::ST_ID_BIT] = id_mode;
                rd_word[fcs_pkg::ST_SEC_BIT] = mac_secure_i;
                rd_word[fcs_pkg::ST_LDBLK_BIT] = loader_blocked_o;
                rd_word[fcs_pkg::ST_MODE_LSB +: 2] = mode_i;
            end
        end else if (busy) begin
            rd_word[fcs_pkg::TOGGLE_BIT] = tog;
        end else if (par_lock) begin
            rd_word = 32'h0;
        end else if (id_mode) begin
            if (fadr == fcs_pkg::ID_VENDOR_ADR) begin
                rd_word[7:0] = VENDOR_ID;
            end else if (fadr == fcs_pkg::ID_MACRO_ADR) begin
                rd_word[7:0] = MACRO_ID;
            end else if (fadr == fcs_pkg::ID_SIZE_ADR) begin
                rd_word[7:0] = SIZE_CODE;
            end else if (fadr == fcs_pkg::SEC_ADR) begin
                rd_word[7:0] = mac_secure_i ? fcs_pkg::SEC_ON_BYTE
                    : fcs_pkg::ERASED_BYTE;
            end else begin
                rd_word[7:0] = fcs_pkg::ERASED_BYTE;
            end
        end
    end

    // Bus answer: one edge for registers, two for macro reads
    // Macro data is valid one edge after mac_adr_o is loaded
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            pend <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= 1'b0;
            if (pend) begin
                pend <= 1'b0;
                ack_o <= 1'b1;
                dat_o <= {24'h0, mac_rdat_i};
            end else if (req) begin
                if (rd_mac) begin
                    pend <= 1'b1;
                end else begin
                    ack_o <= 1'b1;
                    dat_o <= we_i ? 32'h0 : rd_word;
                end
            end
        end
    end

    // Control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cen <= fcs_pkg::CEN_LOCK;
        end else if (req & we_i & is_reg & sel_i[0]
                     & (rofs == fcs_pkg::REG_CTRL_OFS)) begin
            cen <= dat_i[fcs_pkg::CEN_LSB +: 4];
        end
    end

    // Status outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
            loader_blocked_o <= 1'b0;
            wdt_disable_o <= 1'b0;
        end else begin
            busy_o <= busy;
            loader_blocked_o <= mac_secure_i
                & (mode_i == fcs_pkg::MODE_SERIAL);
            // Level flags, recomputed every cycle from the mode pins
            // Watchdog off in loader
            wdt_disable_o <= loader_active_i
                & (mode_i == fcs_pkg::MODE_SERIAL);
        end
    end

    // Toggle bit: any busy flash read flips it; software polls one
    // address, so the exact address is not compared
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tog <= 1'b1;
        end else if (!busy) begin
            tog <= 1'b1;
        end else if (rd_flash) begin
            tog <= ~tog;
        end
    end

    // Command decoder and operation timer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            busy_cnt <= 32'h0;
            id_mode <= 1'b0;
            mac_adr_o <= 20'h0;
            mac_wdat_o <= 8'h0;
            mac_prog_o <= 1'b0;
            mac_sect_erase_o <= 1'b0;
            mac_chip_erase_o <= 1'b0;
            mac_sec_set_o <= 1'b0;
        end else begin
            mac_prog_o <= 1'b0;
            mac_sect_erase_o <= 1'b0;
            mac_chip_erase_o <= 1'b0;
            mac_sec_set_o <= 1'b0;
            if (rd_mac) begin
                mac_adr_o <= fadr;
            end
            if (busy) begin
                // Counting from N-1 keeps the state busy N cycles
                // Writes ignored until done
                if (busy_cnt == 32'h0) begin
                    state <= ST_IDLE;
                end else begin
                    busy_cnt <= busy_cnt - 32'h1;
                end
            end else if (cmd_wr) begin
                if (!run_en) begin
                    state <= ST_IDLE;
                end else begin
                    state <= ST_IDLE;
                    unique case (state)
                        ST_IDLE: begin
                            if (id_mode
                                && wdat == fcs_pkg::CMD_ID_EXIT) begin
                                // A lone F0H anywhere leaves ID mode
                                // Short exit form
                                id_mode <= 1'b0;
                            end else if (hit1) begin
                                state <= ST_UNL1;
                            end
                        end
                        ST_UNL1: begin
                            if (hit2) begin
                                state <= ST_UNL2;
                            end
                        end
                        ST_UNL2: begin
                            if (fadr == fcs_pkg::UNLOCK1_ADR) begin
                                if (wdat == fcs_pkg::CMD_PROG) begin
                                    state <= ST_PROG;
                                end else if (wdat == fcs_pkg::CMD_ERASE) begin
                                    state <= ST_ERA1;
                                end else if (wdat == fcs_pkg::CMD_SEC) begin
                                    state <= ST_SEC;
                                end else if (wdat
                                    == fcs_pkg::CMD_ID_ENTRY) begin
                                    id_mode <= 1'b1;
                                end else if (wdat
                                    == fcs_pkg::CMD_ID_EXIT) begin
                                    id_mode <= 1'b0;
                                end
                            end
                        end
                        ST_PROG: begin
                            if (!prog_block) begin
                                state <= ST_BUSY;
                                busy_cnt <= 32'(PROG_CYC - 1);
                                mac_adr_o <= fadr;
                                mac_wdat_o <= wdat;
                                mac_prog_o <= 1'b1;
                            end
                        end
                        ST_ERA1: begin
                            if (hit1) begin
                                state <= ST_ERA2;
                            end
                        end
                        ST_ERA2: begin
                            if (hit2) begin
                                state <= ST_ERA3;
                            end
                        end
                        ST_ERA3: begin
                            if (wdat == fcs_pkg::SUB_CHIP
                                && fadr == fcs_pkg::UNLOCK1_ADR) begin
                                // Allowed when secured: the only way out
                                // Whole array to FFH
                                state <= ST_BUSY;
                                busy_cnt <= 32'(CHIP_ERASE_CYC - 1);
                                mac_chip_erase_o <= 1'b1;
                            end else if (wdat == fcs_pkg::SUB_SECTOR
                                && mode_i != fcs_pkg::MODE_PARALLEL) begin
                                state <= ST_BUSY;
                                busy_cnt <= 32'(SECT_ERASE_CYC - 1);
                                mac_adr_o <= {fadr[19:fcs_pkg::SECT_LSB],
                                    12'h000};
                                mac_sect_erase_o <= 1'b1;
                            end
                        end
                        ST_SEC: begin
                            if (fadr == fcs_pkg::SEC_ADR
                                && wdat == fcs_pkg::SEC_DAT) begin
                                state <= ST_BUSY;
                                busy_cnt <= 32'(SEC_CYC - 1);
                                mac_sec_set_o <= 1'b1;
                            end
                        end
                        ST_BUSY: begin
                            state <= ST_BUSY;
                        end
                    endcase
                end
            end
        end
    end

endmodule : fcs_sequencer

// ---- tb/fcs_macro_model.sv ----
/*
 * Behavioural flash macro beside the sequencer: byte array, program,
 * sector and chip erase, and a nonvolatile security flag.
 * Assumes one-cycle start pulses and combinational reads.
 */
`timescale 1ns/100ps
module fcs_macro_model (
    // Clock
    input wire logic clk_i,
    // Requests from the sequencer
    input wire logic [19:0] adr_i,
    input wire logic [7:0] wdat_i,
    input wire logic prog_i,
    input wire logic sect_erase_i,
    input wire logic chip_erase_i,
    input wire logic sec_set_i,
    // Answers
    output logic [7:0] rdat_o,
    output logic secure_o
);
    logic [7:0] mem [0:131071];

    initial begin
        secure_o = 1'b0;
        for (int i = 0; i < 131072; i++) begin
            mem[i] = 8'hff;
        end
    end

    assign rdat_o = mem[adr_i[16:0]];

    always @(posedge clk_i) begin
        if (prog_i) begin
            mem[adr_i[16:0]] <= mem[adr_i[16:0]] & wdat_i;
        end
        if (sect_erase_i) begin
            for (int i = 0; i < 4096; i++) begin
                mem[{adr_i[16:12], i[11:0]}] <= 8'hff;
            end
        end
        if (chip_erase_i) begin
            for (int i = 0; i < 131072; i++) begin
                mem[i] <= 8'hff;
            end
            secure_o <= 1'b0;
        end
        if (sec_set_i) begin
            secure_o <= 1'b1;
        end
    end
endmodule : fcs_macro_model

// ---- tb/fcs_seq_chk.sv ----
/*
 * Port assertions for the flash command sequencer.
 * Assumes it is bound to fcs_sequencer; one clock, synchronous reset.
 */
`timescale 1ns/100ps
module fcs_seq_chk (
    // Clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [fcs_pkg::WB_AW-1:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Mode and macro
    input wire fcs_pkg::fcs_mode_t mode_i,
    input wire logic loader_active_i,
    input wire logic mac_secure_i,
    input wire logic [19:0] mac_adr_o,
    input wire logic mac_prog_o,
    input wire logic mac_sect_erase_o,
    input wire logic mac_chip_erase_o,
    input wire logic mac_sec_set_o,
    // Status
    input wire logic busy_o,
    input wire logic loader_blocked_o,
    input wire logic wdt_disable_o
);
    logic start;
    assign start = mac_prog_o | mac_sect_erase_o | mac_chip_erase_o
        | mac_sec_set_o;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    req_answer_a: assert property (
        cyc_i && stb_i && !ack_o |-> ##[1:2] ack_o)
        else $error("request not answered in time");
    sect_mode_a: assert property (
        $past(mode_i) == fcs_pkg::MODE_PARALLEL |-> !mac_sect_erase_o)
        else $error("sector erase in parallel mode");
    sect_base_a: assert property (
        mac_sect_erase_o |-> mac_adr_o[11:0] == 12'h000)
        else $error("sector erase address not a sector base");
    busy_follow_a: assert property (start |-> ##[0:2] busy_o)
        else $error("busy not raised after start");
    busy_hold_a: assert property (busy_o && $past(busy_o) |-> !start)
        else $error("operation started while busy");
    start_single_a: assert property (start |-> $onehot0({mac_prog_o,
        mac_sect_erase_o, mac_chip_erase_o, mac_sec_set_o}) ##1 !start)
        else $error("start pulses overlap or stretch");
    prog_secure_a: assert property (mac_prog_o |-> !(mac_secure_i
        && mode_i != fcs_pkg::MODE_MCU)) else $error("program while secured");
    blk_flag_a: assert property (
        !$past(rst_i) |-> loader_blocked_o
        == $past(mac_secure_i && mode_i == fcs_pkg::MODE_SERIAL))
        else $error("loader block flag wrong");
    wdt_flag_a: assert property (
        !$past(rst_i) |-> wdt_disable_o
        == $past(loader_active_i && mode_i == fcs_pkg::MODE_SERIAL))
        else $error("watchdog hold flag wrong");
    toggle_only_a: assert property (
        ack_o && !we_i && !adr_i[23] && busy_o && $past(busy_o)
        |-> (dat_o & ~32'h40) == 32'h0)
        else $error("busy read carries more than the toggle bit");

    cover property (mac_prog_o);
    cover property (mac_sect_erase_o);
    cover property (mac_chip_erase_o);
    cover property (mac_sec_set_o);
endmodule : fcs_seq_chk

bind fcs_sequencer fcs_seq_chk fcs_seq_chk_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o),
    .ack_o(ack_o), .mode_i(mode_i), .loader_active_i(loader_active_i),
    .mac_secure_i(mac_secure_i), .mac_adr_o(mac_adr_o),
    .mac_prog_o(mac_prog_o), .mac_sect_erase_o(mac_sect_erase_o),
    .mac_chip_erase_o(mac_chip_erase_o), .mac_sec_set_o(mac_sec_set_o),
    .busy_o(busy_o), .loader_blocked_o(loader_blocked_o),
    .wdt_disable_o(wdt_disable_o));

// ---- tb/tb_top.sv ----
/*
 * Self-checking bench for the flash command sequencer over Wishbone.
 * Assumes the macro model beside the design and the bound checker.
 */
`timescale 1ns/100ps
module tb_top;
    logic clk_i, rst_i, cyc, stb, we, ack_o, loader, secure, wdt_o;
    logic prog, sect, chip, secset, busy_o, blk_o;
    logic [23:0] adr;
    logic [31:0] wdat, dat_o, q;
    logic [19:0] mac_adr;
    logic [7:0] mac_wdat, rdat;
    fcs_pkg::fcs_mode_t mode;
    int error_cnt = 0;
    int checks_done = 0;
    localparam logic [19:0] U1 = fcs_pkg::UNLOCK1_ADR;
    localparam logic [23:0] CTRL = 24'h800000;
    localparam logic [23:0] STAT = 24'h800004;
    logic [19:0] ida [4] = '{20'h04000, 20'h04001, 20'h04002, 20'h04f7f};
    localparam logic [7:0] VID = 8'h5a; // Arbitrary maker byte
    localparam logic [7:0] MID = 8'h3c; // Arbitrary macro byte
    logic [7:0] idv [4] = '{VID, MID, fcs_pkg::SIZE_16K,
        fcs_pkg::ERASED_BYTE};

    fcs_sequencer #(.SECT_ERASE_CYC(20), .CHIP_ERASE_CYC(20), .PROG_CYC(20),
        .SEC_CYC(20), .VENDOR_ID(VID), .MACRO_ID(MID),
        .SIZE_CODE(fcs_pkg::SIZE_16K)) fcs_sequencer_inst (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
        .mode_i(mode), .loader_active_i(loader), .mac_adr_o(mac_adr),
        .mac_wdat_o(mac_wdat), .mac_prog_o(prog), .mac_sect_erase_o(sect),
        .mac_chip_erase_o(chip), .mac_sec_set_o(secset), .mac_rdat_i(rdat),
        .mac_secure_i(secure), .busy_o(busy_o), .loader_blocked_o(blk_o),
        .wdt_disable_o(wdt_o));

    fcs_macro_model fcs_macro_model_inst (.clk_i(clk_i), .adr_i(mac_adr),
        .wdat_i(mac_wdat), .prog_i(prog), .sect_erase_i(sect),
        .chip_erase_i(chip), .sec_set_i(secset), .rdat_o(rdat),
        .secure_o(secure));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic report_and_stop;
        $display("Counts: %0d checks, %0d mismatches", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [23:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 40);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack_o !== 1'b1) begin
            error_cnt++;
            $display("MISMATCH at %0t: bus timeout", $time);
            report_and_stop();
        end
    endtask : wb

    task automatic fw(input logic [19:0] fa, input logic [7:0] d);
        wb(1'b1, {2'b00, fa, 2'b00}, {24'h0, d});
    endtask : fw

    task automatic fr(input logic [19:0] fa);
        wb(1'b0, {2'b00, fa, 2'b00}, 32'h0);
    endtask : fr

    task automatic cmd(input logic [7:0] b);
        fw(U1, 8'haa);
        fw(fcs_pkg::UNLOCK2_ADR, 8'h55);
        fw(U1, b);
    endtask : cmd

    task automatic erase(input logic [7:0] sub, input logic [19:0] fa);
        cmd(fcs_pkg::CMD_ERASE);
        fw(U1, 8'haa);
        fw(fcs_pkg::UNLOCK2_ADR, 8'h55);
        fw(fa, sub);
    endtask : erase

    task automatic poll(input logic [19:0] fa);
        logic [31:0] prev;
        int n;
        n = 0;
        fr(fa);
        do begin
            prev = q;
            fr(fa);
            n++;
        end while (q !== prev && n < 200);
        if (q !== prev) begin
            error_cnt++;
            $display("MISMATCH at %0t: polling timeout", $time);
            report_and_stop();
        end
    endtask : poll

    initial begin
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 24'h0;
        wdat = 32'h0;
        mode = fcs_pkg::MODE_MCU;
        loader = 1'b0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, CTRL, 32'h0);
        chk({28'h0, q[7:4]}, 32'hc);
        wb(1'b0, 24'h800010, 32'h0);
        chk(q, 32'h0);
        cmd(fcs_pkg::CMD_PROG);
        fw(20'h0e000, 8'h12);
        fr(20'h0e000);
        chk(q, 32'hff);
        $display("test done: reset and lock");
        wb(1'b1, CTRL, 32'h30);
        cmd(fcs_pkg::CMD_PROG);
        fw(20'h0e000, 8'h12);
        fr(20'h0e000);
        chk(q, 32'h40);
        fr(20'h0e000);
        chk(q, 32'h0);
        poll(20'h0e000);
        chk(q, 32'h12);
        cmd(fcs_pkg::CMD_PROG);
        fw(20'h0f001, 8'h55);
        cmd(fcs_pkg::CMD_PROG);
        fw(20'h0f002, 8'h66);
        poll(20'h0f001);
        chk(q, 32'h55);
        fr(20'h0f002);
        chk(q, 32'hff);
        $display("test done: program and busy");
        erase(fcs_pkg::SUB_SECTOR, 20'h0f123);
        poll(20'h0f001);
        chk(q, 32'hff);
        fr(20'h0e000);
        chk(q, 32'h12);
        fw(U1, 8'haa);
        fw(fcs_pkg::UNLOCK2_ADR, 8'h55);
        fw(20'h0e001, 8'h77);
        fw(U1, fcs_pkg::CMD_PROG);
        fw(20'h0e002, 8'h99);
        fr(20'h0e002);
        chk(q, 32'hff);
        $display("test done: sector erase and abort");
        cmd(fcs_pkg::CMD_ID_ENTRY);
        for (int i = 0; i < 4; i++) begin
            fr(ida[i]);
            chk(q, {24'h0, idv[i]});
        end
        cmd(fcs_pkg::CMD_ID_EXIT);
        fr(20'h0e000);
        chk(q, 32'h12);
        $display("test done: identification");
        cmd(fcs_pkg::CMD_SEC);
        fw(fcs_pkg::SEC_ADR, 8'h00);
        fr(20'h0e000);
        chk(q, 32'h40);
        poll(20'h0e000);
        @(posedge clk_i);
        mode <= fcs_pkg::MODE_SERIAL;
        loader <= 1'b1;
        wb(1'b0, STAT, 32'h0);
        chk(q, 32'h1c);
        chk({31'h0, wdt_o}, 32'h1);
        cmd(fcs_pkg::CMD_PROG);
        fw(20'h0e004, 8'h00);
        fr(20'h0e004);
        chk(q, 32'hff);
        cmd(fcs_pkg::CMD_ID_ENTRY);
        fr(fcs_pkg::SEC_ADR);
        chk(q, 32'h0);
        fw(20'h0e000, fcs_pkg::CMD_ID_EXIT);
        @(posedge clk_i);
        mode <= fcs_pkg::MODE_PARALLEL;
        loader <= 1'b0;
        fr(20'h0e000);
        chk(q, 32'h0);
        erase(fcs_pkg::SUB_SECTOR, 20'h0e000);
        @(posedge clk_i);
        mode <= fcs_pkg::MODE_MCU;
        fr(20'h0e000);
        chk(q, 32'h12);
        $display("test done: security");
        erase(fcs_pkg::SUB_CHIP, U1);
        poll(20'h0e000);
        chk(q, 32'hff);
        wb(1'b0, STAT, 32'h0);
        chk(q, 32'h0);
        wb(1'b1, CTRL, 32'hc0);
        $display("test done: chip erase");
        report_and_stop();
    end
endmodule : tb_top
